// file: pkg/clkstate_pkg.sv
// Constants, types and register map of the CPU clock source state machine.
// Summary of operation
// - After reset release the CPU runs on the internal fast oscillator, state B.
// - Dual-threshold mode: wait supply above threshold, then reset processing 11 to 45 us.
// - Setup steps may be skipped when target clock already runs or fields set.
// - Halt moves B to E, C to F, D to G keeping the clock source.
// - Stop from B gives H, from C gives I; never from the subsystem clock.
// - Oscillator mode select holds bits 7, 6, 5, 4 and amplifier select bit 0.
// - Main oscillator stop is bit 7 of main oscillator control; 0 lets it run.
// - Main system source select is bit 2, main-to-CPU select bit 0.
// - Subsystem select is bit 4 of processor clock control; 1 selects sub clock.
// - Internal fast oscillator status is bit 7, stop control bit 0.
// - Amplifier select rising stalls CPU 4.06 to 16.12 us, or 160 external clocks.
package clkstate_pkg;

  localparam logic [2:0] OFS_OSC_MODE = 3'h0;
  localparam logic [2:0] OFS_MAIN_OSC = 3'h1;
  localparam logic [2:0] OFS_MAIN_MODE = 3'h2;
  localparam logic [2:0] OFS_PROC_CLK = 3'h3;
  localparam logic [2:0] OFS_INT_OSC = 3'h4;

  localparam int BIT_EXT_MAIN = 7;
  localparam int BIT_MAIN_PIN = 6;
  localparam int BIT_EXT_SUB = 5;
  localparam int BIT_SUB_PIN = 4;
  localparam int BIT_AMP = 0;
  localparam int BIT_MAIN_STOP = 7;
  localparam int BIT_MAIN_SRC = 2;
  localparam int BIT_MAIN_CPU = 0;
  localparam int BIT_MAIN_ACTIVE = 5;
  localparam int BIT_SUB_SEL = 4;
  localparam int BIT_SUB_ACTIVE = 5;
  localparam int BIT_FAST_STATUS = 7;
  localparam int BIT_FAST_STOP = 0;

  localparam logic [7:0] MASK_OSC_MODE = 8'hF1;
  localparam logic [7:0] MASK_MAIN_OSC = 8'h80;
  localparam logic [7:0] MASK_MAIN_MODE = 8'h05;
  localparam logic [7:0] MASK_PROC_CLK = 8'h10;
  localparam logic [7:0] MASK_INT_OSC = 8'h01;

  localparam logic [7:0] RST_OSC_MODE = 8'h00;
  localparam logic [7:0] RST_MAIN_OSC = 8'h80;
  localparam logic [7:0] RST_MAIN_MODE = 8'h00;
  localparam logic [7:0] RST_PROC_CLK = 8'h00;
  localparam logic [7:0] RST_INT_OSC = 8'h00;

  localparam int CLK_PERIOD_PS = 4000;
  localparam int RESET_PROC_MIN_PS = 11000000;
  localparam int RESET_PROC_CYC = (RESET_PROC_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int AMP_STALL_MIN_PS = 4060000;
  localparam int AMP_STALL_CYC = (AMP_STALL_MIN_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int AMP_EXT_TICKS = 160;

  typedef enum logic [1:0] {SRC_FAST, SRC_MAIN, SRC_SUB} src_t;
  typedef enum {ST_A, ST_B, ST_C, ST_D, ST_E, ST_F, ST_G, ST_H, ST_I} cpu_state_t;
  typedef enum {SW_RUN, SW_DRAIN, SW_ARM} sw_state_t;

endpackage : clkstate_pkg

// file: pkg/clk_sel_if.sv
// Carrier between the clock state machine and the glitch-free source switch.
`timescale 1ns/1ps
`default_nettype none
interface clk_sel_if;
  import clkstate_pkg::*;
  src_t want;
  logic [2:0] tick;
  logic gate;
  src_t cur;
  logic en;
  logic busy;
  modport ctrl (output want, output tick, output gate, input cur, input en, input busy);
  modport sw (input want, input tick, input gate, output cur, output en, output busy);
endinterface : clk_sel_if
`default_nettype wire

// file: src/clock_switch.sv
// Glitch-free CPU clock enable selector between three source ticks.
`timescale 1ns/1ps
`default_nettype none
module clock_switch
  import clkstate_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  clk_sel_if.sw sel
);

  sw_state_t sw_state_reg;
  sw_state_t sw_state_next;
  src_t cur_reg;
  src_t cur_next;
  logic en_reg;
  logic en_next;

  function automatic logic tick_of(input src_t s, input logic [2:0] t);
    case (s)
      SRC_MAIN: tick_of = t[1];
      SRC_SUB: tick_of = t[2];
      default: tick_of = t[0];
    endcase
  endfunction : tick_of

  wire logic cur_tick = tick_of(cur_reg, sel.tick);

  always_comb begin
    sw_state_next = sw_state_reg;
    cur_next = cur_reg;
    case (sw_state_reg)
      SW_RUN: begin
        if (sel.want != cur_reg) begin
          sw_state_next = SW_DRAIN;
        end
      end
      SW_DRAIN: begin
        if (cur_tick) begin
          cur_next = sel.want;
          sw_state_next = SW_ARM;
        end
      end
      SW_ARM: begin
        if (cur_tick) begin
          sw_state_next = SW_RUN;
        end
      end
      default: sw_state_next = SW_RUN;
    endcase
  end

  // Output pulses only in the run phase, so no shortened period can escape.
  assign en_next = (sw_state_reg == SW_RUN) && (sel.want == cur_reg) && sel.gate && cur_tick;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      sw_state_reg <= SW_RUN;
      cur_reg <= SRC_FAST;
      en_reg <= 1'b0;
    end else begin
      sw_state_reg <= sw_state_next;
      cur_reg <= cur_next;
      en_reg <= en_next;
    end
  end

  assign sel.cur = cur_reg;
  assign sel.en = en_reg;
  assign sel.busy = (sw_state_reg != SW_RUN);

  AST_SW_QUIET: assert property (@(posedge CLK) disable iff (SRST)
    (sw_state_reg != SW_RUN) |=> !en_reg)
    else $error("Clock enable pulsed while switching source.");

  AST_SW_ARM_WAIT: assert property (@(posedge CLK) disable iff (SRST)
    (sw_state_reg == SW_ARM && !cur_tick) |=> (sw_state_reg == SW_ARM) && $stable(cur_reg))
    else $error("Switch left arm phase without a tick of the new source.");

endmodule : clock_switch
`default_nettype wire

// file: src/cpu_clock_ctrl.sv
// CPU clock source state machine with its clock control registers.
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_ctrl
  import clkstate_pkg::*;
(
  input wire logic CLK,
  input wire logic SRST,
  input wire logic [2:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic POR_MODE,
  input wire logic SUPPLY_OK,
  input wire logic HALT_REQ,
  input wire logic STOP_REQ,
  input wire logic WAKE_REQ,
  input wire logic FAST_TICK,
  input wire logic MAIN_TICK,
  input wire logic SUB_TICK,
  input wire logic MAIN_STABLE,
  output logic CPU_CLK_EN,
  output logic [3:0] CPU_STATE,
  output logic CPU_IN_RESET,
  output logic FAST_OSC_RUN,
  output logic MAIN_OSC_RUN,
  output logic SUB_OSC_RUN
);

  clk_sel_if sel ();

  logic [7:0] oscillator_mode_select_reg;
  logic [7:0] main_oscillator_control_reg;
  logic [7:0] main_clock_mode_reg;
  logic [7:0] processor_clock_control_reg;
  logic [7:0] internal_oscillator_mode_reg;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  cpu_state_t state_reg;
  cpu_state_t state_next;
  logic [11:0] rst_cnt_reg;
  logic [11:0] rst_cnt_next;
  logic [10:0] stall_cnt_reg;
  logic [10:0] stall_cnt_next;
  logic fast_run_reg;
  logic main_run_reg;
  logic sub_run_reg;
  src_t want_reg;
  src_t want_next;

  localparam logic [11:0] RST_LAST = 12'(RESET_PROC_CYC - 1);
  localparam logic [10:0] AMP_XTAL_LOAD = 11'(AMP_STALL_CYC);
  localparam logic [10:0] AMP_EXT_LOAD = 11'(AMP_EXT_TICKS);

  function automatic cpu_state_t run_state(input src_t s);
    case (s)
      SRC_MAIN: run_state = ST_C;
      SRC_SUB: run_state = ST_D;
      default: run_state = ST_B;
    endcase
  endfunction : run_state

  function automatic logic [3:0] state_code(input cpu_state_t s);
    case (s)
      ST_A: state_code = 4'h0;
      ST_B: state_code = 4'h1;
      ST_C: state_code = 4'h2;
      ST_D: state_code = 4'h3;
      ST_E: state_code = 4'h4;
      ST_F: state_code = 4'h5;
      ST_G: state_code = 4'h6;
      ST_H: state_code = 4'h7;
      default: state_code = 4'h8;
    endcase
  endfunction : state_code

  // Register write decode.
  wire logic wr_osc = WR && (ADDR == OFS_OSC_MODE);
  wire logic wr_moc = WR && (ADDR == OFS_MAIN_OSC);
  wire logic wr_mcm = WR && (ADDR == OFS_MAIN_MODE);
  wire logic wr_pcc = WR && (ADDR == OFS_PROC_CLK);
  wire logic wr_rcm = WR && (ADDR == OFS_INT_OSC);

  wire logic ext_main_input_sel = oscillator_mode_select_reg[BIT_EXT_MAIN];
  wire logic main_pin_osc_enable = oscillator_mode_select_reg[BIT_MAIN_PIN];
  wire logic ext_sub_input_sel = oscillator_mode_select_reg[BIT_EXT_SUB];
  wire logic sub_pin_osc_enable = oscillator_mode_select_reg[BIT_SUB_PIN];
  wire logic high_freq_amp_sel = oscillator_mode_select_reg[BIT_AMP];
  wire logic main_osc_stop = main_oscillator_control_reg[BIT_MAIN_STOP];
  wire logic main_system_src_sel = main_clock_mode_reg[BIT_MAIN_SRC];
  wire logic main_to_cpu_sel = main_clock_mode_reg[BIT_MAIN_CPU];
  wire logic cpu_subsystem_sel = processor_clock_control_reg[BIT_SUB_SEL];
  wire logic internal_fast_osc_stop = internal_oscillator_mode_reg[BIT_FAST_STOP];

  wire logic run_state_now = (state_reg == ST_B) || (state_reg == ST_C) || (state_reg == ST_D);
  wire logic halt_state_now = (state_reg == ST_E) || (state_reg == ST_F) || (state_reg == ST_G);
  wire logic stop_state_now = (state_reg == ST_H) || (state_reg == ST_I);

  // The crystal case needs the stabilization counter; an external clock is usable at once.
  wire logic main_ready = main_pin_osc_enable && !main_osc_stop && (ext_main_input_sel || MAIN_STABLE);
  // The sub crystal settling is timed by software, so only the pin enable gates it.
  wire logic sub_ready = sub_pin_osc_enable;
  wire logic fast_ready = !internal_fast_osc_stop;

  wire src_t target_src = cpu_subsystem_sel ? SRC_SUB :
                          (main_system_src_sel && main_to_cpu_sel) ? SRC_MAIN : SRC_FAST;
  wire logic target_ok = (target_src == SRC_FAST) ? fast_ready :
                         (target_src == SRC_MAIN) ? main_ready : sub_ready;

  always_comb begin
    want_next = want_reg;
    if (run_state_now && target_ok) begin
      want_next = target_src;
    end
  end

  wire logic amp_rise = wr_osc && WDATA[BIT_AMP] && !high_freq_amp_sel;
  wire logic stall_step = ext_main_input_sel ? MAIN_TICK : 1'b1;
  always_comb begin
    stall_cnt_next = stall_cnt_reg;
    if (amp_rise) begin
      stall_cnt_next = WDATA[BIT_EXT_MAIN] ? AMP_EXT_LOAD : AMP_XTAL_LOAD;
    end else if ((stall_cnt_reg != 11'h000) && stall_step) begin
      stall_cnt_next = stall_cnt_reg - 11'h001;
    end
  end

  wire logic rst_counting = (state_reg == ST_A) && (!POR_MODE || SUPPLY_OK);
  assign rst_cnt_next = rst_counting ? (rst_cnt_reg + 12'h001) : 12'h000;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_A: begin
        if (rst_counting && (rst_cnt_reg == RST_LAST)) begin
          state_next = ST_B;
        end
      end
      ST_B, ST_C, ST_D: begin
        if (HALT_REQ) begin
          state_next = (state_reg == ST_B) ? ST_E : (state_reg == ST_C) ? ST_F : ST_G;
        end else if (STOP_REQ && (state_reg != ST_D)) begin
          state_next = (state_reg == ST_B) ? ST_H : ST_I;
        end else begin
          state_next = run_state(sel.cur);
        end
      end
      ST_E, ST_F, ST_G, ST_H, ST_I: begin
        if (WAKE_REQ) begin
          state_next = run_state(sel.cur);
        end
      end
      default: state_next = ST_A;
    endcase
  end

  // Read mux; main and sub status bits show the source actually feeding the CPU, the fast status bit shows the fast oscillator running.
  always_comb begin
    rdata_next = 8'h00;
    if (RD) begin
      case (ADDR)
        OFS_OSC_MODE: rdata_next = oscillator_mode_select_reg;
        OFS_MAIN_OSC: rdata_next = main_oscillator_control_reg;
        OFS_MAIN_MODE: begin
          rdata_next = main_clock_mode_reg;
          rdata_next[BIT_MAIN_ACTIVE] = (sel.cur == SRC_MAIN);
        end
        OFS_PROC_CLK: begin
          rdata_next = processor_clock_control_reg;
          rdata_next[BIT_SUB_ACTIVE] = (sel.cur == SRC_SUB);
        end
        OFS_INT_OSC: begin
          rdata_next = internal_oscillator_mode_reg;
          rdata_next[BIT_FAST_STATUS] = fast_run_reg;
        end
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      oscillator_mode_select_reg <= RST_OSC_MODE;
      main_oscillator_control_reg <= RST_MAIN_OSC;
      main_clock_mode_reg <= RST_MAIN_MODE;
      processor_clock_control_reg <= RST_PROC_CLK;
      internal_oscillator_mode_reg <= RST_INT_OSC;
    end else begin
      if (wr_osc) oscillator_mode_select_reg <= WDATA & MASK_OSC_MODE;
      if (wr_moc) main_oscillator_control_reg <= WDATA & MASK_MAIN_OSC;
      if (wr_mcm) main_clock_mode_reg <= WDATA & MASK_MAIN_MODE;
      if (wr_pcc) processor_clock_control_reg <= WDATA & MASK_PROC_CLK;
      if (wr_rcm) internal_oscillator_mode_reg <= WDATA & MASK_INT_OSC;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_reg <= ST_A;
      rst_cnt_reg <= 12'h000;
      stall_cnt_reg <= 11'h000;
      want_reg <= SRC_FAST;
      rdata_reg <= 8'h00;
    end else begin
      state_reg <= state_next;
      rst_cnt_reg <= rst_cnt_next;
      stall_cnt_reg <= stall_cnt_next;
      want_reg <= want_next;
      rdata_reg <= rdata_next;
    end
  end

  // A source that still feeds the CPU keeps running even if its stop bit is set.
  // Stop mode parks both main-side oscillators; the sub clock survives it.
  always_ff @(posedge CLK) begin
    if (SRST) begin
      fast_run_reg <= 1'b0;
      main_run_reg <= 1'b0;
      sub_run_reg <= 1'b0;
    end else begin
      fast_run_reg <= !stop_state_now && (fast_ready || (sel.cur == SRC_FAST));
      main_run_reg <= !stop_state_now && main_pin_osc_enable &&
                      (!main_osc_stop || (sel.cur == SRC_MAIN));
      sub_run_reg <= sub_pin_osc_enable || (sel.cur == SRC_SUB);
    end
  end

  assign sel.want = want_reg;
  assign sel.tick = {SUB_TICK && sub_run_reg, MAIN_TICK && main_run_reg, FAST_TICK && fast_run_reg};
  assign sel.gate = run_state_now && (stall_cnt_reg == 11'h000) && (state_next == state_reg);

  clock_switch u_switch (
    .CLK(CLK),
    .SRST(SRST),
    .sel(sel)
  );

  logic [3:0] state_out_reg;
  logic in_reset_reg;
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_out_reg <= 4'h0;
      in_reset_reg <= 1'b1;
    end else begin
      state_out_reg <= state_code(state_reg);
      in_reset_reg <= (state_reg == ST_A);
    end
  end

  assign RDATA = rdata_reg;
  assign CPU_CLK_EN = sel.en;
  assign CPU_STATE = state_out_reg;
  assign CPU_IN_RESET = in_reset_reg;
  assign FAST_OSC_RUN = fast_run_reg;
  assign MAIN_OSC_RUN = main_run_reg;
  assign SUB_OSC_RUN = sub_run_reg;

  AST_RELEASE_TO_B: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == ST_B && $past(state_reg == ST_A)) |-> $past(rst_cnt_reg) == RST_LAST)
    else $error("Left reset state before reset processing finished.");

  AST_SUPPLY_WAIT: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == ST_A && POR_MODE && !SUPPLY_OK) |=> (state_reg == ST_A) && (rst_cnt_reg == 12'h000))
    else $error("Reset processing ran below the supply threshold.");

  AST_HALT_FROM_C: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == ST_C && HALT_REQ) |=> (state_reg == ST_F) && (sel.cur == SRC_MAIN))
    else $error("Halt from main clock did not reach state F.");

  AST_HALT_FROM_D: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == ST_D && HALT_REQ) |=> state_reg == ST_G)
    else $error("Halt from subsystem clock did not reach state G.");

  AST_NO_STOP_SUB: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == ST_D && STOP_REQ && !HALT_REQ) |=> state_reg != ST_H && state_reg != ST_I)
    else $error("Stop entered from the subsystem clock.");

  AST_STOP_FROM_B: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == ST_B && STOP_REQ && !HALT_REQ) |=> state_reg == ST_H ##1 !CPU_CLK_EN)
    else $error("Stop from internal clock did not reach state H.");

  AST_OSC_FIELDS: assert property (@(posedge CLK) disable iff (SRST)
    wr_osc |=> oscillator_mode_select_reg == ($past(WDATA) & 8'hF1))
    else $error("Mode select register did not take its five fields.");

  AST_MAIN_MODE_READ: assert property (@(posedge CLK) disable iff (SRST)
    (RD && ADDR == OFS_MAIN_MODE) |=> RDATA[0] == $past(main_to_cpu_sel) && RDATA[2] == $past(main_system_src_sel))
    else $error("Main clock mode read back wrong select bits.");

  AST_AMP_STALL: assert property (@(posedge CLK) disable iff (SRST)
    (amp_rise && !WDATA[BIT_EXT_MAIN]) |=> (stall_cnt_reg == AMP_XTAL_LOAD) ##1 !CPU_CLK_EN [*3])
    else $error("Amplifier select did not stall the CPU clock.");

  AST_NO_STOPPED_TARGET: assert property (@(posedge CLK) disable iff (SRST)
    (want_reg != $past(want_reg)) |-> $past(target_ok))
    else $error("CPU clock steered to a stopped oscillator.");

  AST_STATE_SOURCE: assert property (@(posedge CLK) disable iff (SRST)
    (state_reg == ST_G) |-> sel.cur == SRC_SUB)
    else $error("Halt state G without the subsystem clock.");

endmodule : cpu_clock_ctrl
`default_nettype wire

// file: dv/cpu_clock_ctrl_tb.sv
// Self-checking bench for the CPU clock source state machine.
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_ctrl_tb;
  import clkstate_pkg::*;
  logic clk, srst, wr, rd, por_mode, supply_ok, halt_req, stop_req, wake_req;
  logic fast_tick, main_tick, sub_tick, main_stable, cpu_clk_en, cpu_in_reset, fast_run, main_run, sub_run;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic [3:0] cpu_state;
  int bad_count, cmp_count, en_cnt, mt_cnt, st, e0, m0;
  int reg_m [8];
  logic [7:0] mask [8] = '{MASK_OSC_MODE, MASK_MAIN_OSC, MASK_MAIN_MODE, MASK_PROC_CLK, MASK_INT_OSC, 8'h00, 8'h00, 8'h00};
  logic [7:0] safe [5] = '{8'hF0, 8'hFF, 8'hFA, 8'hEF, 8'hFE};

  cpu_clock_ctrl i_cpu_clock_ctrl (.CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata), .POR_MODE(por_mode), .SUPPLY_OK(supply_ok), .HALT_REQ(halt_req), .STOP_REQ(stop_req),
    .WAKE_REQ(wake_req), .FAST_TICK(fast_tick), .MAIN_TICK(main_tick), .SUB_TICK(sub_tick),
    .MAIN_STABLE(main_stable), .CPU_CLK_EN(cpu_clk_en), .CPU_STATE(cpu_state), .CPU_IN_RESET(cpu_in_reset),
    .FAST_OSC_RUN(fast_run), .MAIN_OSC_RUN(main_run), .SUB_OSC_RUN(sub_run));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // Random oscillator ticks keep the source switch from seeing a fixed phase.
  always @(posedge clk) begin
    fast_tick <= ($urandom_range(0, 2) == 0);
    main_tick <= ($urandom_range(0, 1) == 0);
    sub_tick <= ($urandom_range(0, 3) == 0);
    if (cpu_clk_en === 1'b1) en_cnt++;
    if (main_tick === 1'b1) mt_cnt++;
  end

  task automatic finish_test();
    if (bad_count == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test

  task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_int(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      bad_count++;
      $display("MISMATCH %0t count %0d expected %0d", $time, got, exp);
    end
  endtask : chk_int

  task automatic chk_state(input int exp);
    cmp_count++;
    if (cpu_state !== exp[3:0] || cpu_in_reset !== (exp == 0)) begin
      bad_count++;
      $display("MISMATCH %0t state %h expected %0d", $time, cpu_state, exp);
    end
  endtask : chk_state

  // Waits a bounded time for a state; arriving before lo cycles is also an error.
  task automatic wait_state(input int exp, input int lo, input int hi);
    int n;
    n = 0;
    while (n < hi && cpu_state !== exp[3:0]) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk_state(exp);
    chk_int(n < lo, 0);
    st = exp;
  endtask : wait_state

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    reg_m[a] = d & mask[a];
  endtask : wr_reg

  task automatic check_read(input logic [2:0] a);
    int x;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    rv = rdata;
    x = reg_m[a];
    if (a == 3'h2 && st == 2) x = x | 8'h20;
    if (a == 3'h3 && st == 3) x = x | 8'h20;
    if (a == 3'h4) x = x | 8'h80;
    chk_reg(rv, x[7:0]);
  endtask : check_read

  task automatic pulse_req(input int k);
    @(posedge clk);
    halt_req <= (k == 0);
    stop_req <= (k == 1);
    wake_req <= (k == 2);
    @(posedge clk);
    {halt_req, stop_req, wake_req} <= 3'b000;
  endtask : pulse_req

  task automatic go(input int k, input int exp);
    pulse_req(k);
    wait_state(exp, 0, 20);
  endtask : go

  task automatic quiet(input int n);
    e0 = en_cnt;
    repeat (n) @(posedge clk);
    chk_int(en_cnt - e0, 0);
  endtask : quiet

  task automatic do_reset();
    @(posedge clk);
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk_state(0);
    chk_reg({rdata[4:0], fast_run, main_run, sub_run}, 8'h00);
    @(posedge clk);
    srst <= 1'b0;
    reg_m = '{0, 128, 0, 0, 0, 0, 0, 0};
    st = 0;
  endtask : do_reset

  initial begin
    #200000;
    bad_count++;
    finish_test();
  end

  initial begin
    // Reset stands from time zero so no assertion sees unreset state.
    {wr, rd, por_mode, halt_req, stop_req, wake_req} = '0;
    srst = 1'b1;
    {addr, wdata, bad_count, cmp_count, en_cnt, mt_cnt} = '0;
    supply_ok = 1'b1;
    main_stable = 1'b1;
    void'($urandom(3));
    do_reset();
    wait_state(1, 2740, 2760);
    for (int a = 0; a < 5; a++) check_read(a[2:0]);
    repeat (2) begin
      for (int a = 0; a < 8; a++) begin
        wr_reg(a[2:0], $urandom() & ((a < 5) ? safe[a] : 8'hFF));
        check_read(a[2:0]);
      end
    end
    wr_reg(3'h0, 8'h00);
    wr_reg(3'h1, 8'h80);
    go(0, 4);
    quiet(40);
    go(2, 1);
    go(1, 7);
    go(2, 1);
    wr_reg(3'h2, 8'h05);
    repeat (100) @(posedge clk);
    #1 chk_state(1);
    // Amplifier turned on with external main input: stall counted in main ticks.
    wr_reg(3'h0, 8'hC1);
    repeat (2) @(posedge clk);
    e0 = en_cnt;
    m0 = mt_cnt;
    while (mt_cnt - m0 < 155) @(posedge clk);
    chk_int(en_cnt - e0, 0);
    repeat (200) @(posedge clk);
    e0 = en_cnt;
    repeat (60) @(posedge clk);
    chk_int(en_cnt > e0, 1);
    wr_reg(3'h1, 8'h00);
    wait_state(2, 0, 200);
    chk_reg({5'h00, fast_run, main_run, sub_run}, 8'h06);
    check_read(3'h2);
    go(0, 5);
    quiet(40);
    go(2, 2);
    go(1, 8);
    chk_reg({5'h00, fast_run, main_run, sub_run}, 8'h00);
    go(2, 2);
    // sub pin enable then subsystem select
    wr_reg(3'h0, 8'hD1);
    wr_reg(3'h3, 8'h10);
    wait_state(3, 0, 200);
    check_read(3'h3);
    pulse_req(1);
    repeat (20) @(posedge clk);
    #1 chk_state(3);
    go(0, 6);
    go(2, 3);
    wr_reg(3'h3, 8'h00);
    wait_state(2, 0, 200);
    wr_reg(3'h2, 8'h00);
    wait_state(1, 0, 200);
    wr_reg(3'h2, 8'h00);
    repeat (20) @(posedge clk);
    #1 chk_state(1);
    check_read(3'h2);
    // Crystal at 10 MHz or more: amplifier raised again stalls the fast clock by cycles.
    wr_reg(3'h0, 8'h50);
    wr_reg(3'h0, 8'h51);
    // The first pulse after the write may still be launched, so the quiet span starts one edge later.
    @(posedge clk);
    #1 quiet(1000);
    e0 = en_cnt;
    repeat (100) @(posedge clk);
    chk_int(en_cnt > e0, 1);
    // Crystal select must wait for the stabilization counter.
    @(posedge clk);
    main_stable <= 1'b0;
    wr_reg(3'h2, 8'h05);
    repeat (50) @(posedge clk);
    #1 chk_state(1);
    @(posedge clk);
    main_stable <= 1'b1;
    wait_state(2, 0, 200);
    chk_reg({5'h00, fast_run, main_run, sub_run}, 8'h07);
    // Dual-threshold power-on: hold in A until supply is good.
    @(posedge clk);
    por_mode <= 1'b1;
    supply_ok <= 1'b0;
    do_reset();
    repeat (3000) @(posedge clk);
    #1 chk_state(0);
    @(posedge clk);
    supply_ok <= 1'b1;
    wait_state(1, 2740, 2760);
    finish_test();
  end
endmodule : cpu_clock_ctrl_tb
`default_nettype wire
